/* rtl/delay_timer.sv */
/*
  Down counter: done pulses length cycles after the start cycle.
  Assumes start is a one-cycle pulse from logic on hclk.
*/
`timescale 1ns/10ps
module delay_timer (
   input  wire logic hclk,
   input  wire logic hresetn,
   timer_if.timer    tif
);
   import pwr_wake_pkg::*;

   typedef struct packed {
      logic             busy; // Count in progress
      logic [CNT_W-1:0] cnt;  // Remaining cycles
   } tmr_state_t;

   tmr_state_t st_ff;  // Registered state
   tmr_state_t nxt_st; // Next state

   // Load on start, count down, stop after the final cycle
   always_comb begin
      nxt_st = st_ff;
      if (tif.start) begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt  = tif.length;
      end else if (st_ff.busy) begin
         nxt_st.cnt = st_ff.cnt - CNT_ONE;
         if (st_ff.cnt == CNT_ONE) begin
            nxt_st.busy = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tif.done = st_ff.busy && (st_ff.cnt == CNT_ONE);
   assign tif.busy = st_ff.busy;
endmodule // delay_timer

/* rtl/pin_sync.sv */
/*
  Three-stage synchroniser with agreement filter for asynchronous pins.
  Assumes inputs may change at any time relative to hclk.
*/
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = pwr_wake_pkg::SYNC_W
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   import pwr_wake_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1; // Metastability catcher, read only by s2
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;  // Filtered value
   } sync_state_t;

   sync_state_t st_ff;
   sync_state_t nxt_st;

   // Shift stages; a bit changes only once stages two and three agree
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.q[i] = st_ff.s2[i];
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.q;
endmodule // pin_sync

/* rtl/power_down_wake_control.sv */
/*
  Power-down sequencer, wake interrupt routing and peripheral interrupt
  enables and flags, with an AHB-Lite register slave.
  Assumes one slave on the bus, word transfers only, peripheral events
  on hclk, and user pins, clock-ok, bus power and switch asynchronous.
*/
`timescale 1ns/10ps
module power_down_wake_control (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   // AHB-Lite slave
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic      [31:0]                   hrdata,
   // Interrupt sources
   input  wire logic                          rtc_event,
   input  wire logic                          usb_event,
   input  wire logic                          keypad_event,
   input  wire logic                          smartcard_irq,
   input  wire logic [pwr_wake_pkg::USER_PINS-1:0] user_pins,
   // Power environment
   input  wire logic                          clocks_stable,
   input  wire logic                          vbus_present,
   input  wire logic                          onoff_on,
   input  wire logic                          rtc_on_32k,
   // Interrupt outputs to the core
   output logic                               ext_irq0,
   output logic                               ext_irq4,
   output logic                               ext_irq5,
   output logic                               irq,
   // Power and serial controls
   output logic                               analog_clock_off,
   output logic                               converter_off,
   output logic                               mpu_halt,
   output logic                               rtc_run,
   output logic                               power_save_override,
   output logic                               serial_loopback,
   output logic                               serial_pin_select
);
   import pwr_wake_pkg::*;

   // Registered state of the block outside the pin synchroniser and timers
   typedef struct packed {
      pd_state_t  st;           // Sequencer state
      logic [7:0] ext_ctrl;     // Wake control register
      logic [7:0] misc;         // Power and serial control register
      logic [1:0] irq_status;   // Sticky events
      logic [1:0] irq_mask;     // Interrupt enables
      logic       wake_pending; // Delayed wake held on ext_irq0
      reg_sel_t   wr_sel;       // Write in data phase
      logic [31:0] rdata;       // Read data for data phase
   } core_state_t;

   core_state_t core_ff;  // Registered state
   core_state_t nxt_core; // Next state

   logic [SYNC_W-1:0]    pins_s;      // Synchronised pin inputs
   logic [USER_PINS-1:0] user_s;      // Synchronised user pins
   logic                 clk_ok_s;    // Clocks running again
   logic                 vbus_s;      // Bus power present
   logic                 onoff_s;     // Switch in on state

   logic [2:0]           periph_req;  // Enabled peripheral requests
   logic                 irq5_src;    // Sources normally on ext_irq5
   logic                 irq4_src;    // Sources normally on ext_irq4
   logic                 irq0_src;    // Sources normally on ext_irq0
   logic                 wake_any;    // Any wake source
   logic                 route;       // Wake route select bit

   logic                 grace_go;    // Start of grace delay
   logic                 settle_go;   // Start of settle delay

   logic                 addr_valid;  // Address phase taken
   reg_sel_t             addr_sel;    // Register decoded from haddr

   timer_if grace_if ();
   timer_if settle_if ();

   // Pins are asynchronous; three flops and an agreement filter
   pin_sync #(
      .W        (SYNC_W)
   ) u_pin_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({onoff_on, vbus_present, clocks_stable, user_pins}),
      .sync_out (pins_s)
   );

   assign user_s   = pins_s[USER_PINS-1:0];
   assign clk_ok_s = pins_s[USER_PINS];
   assign vbus_s   = pins_s[USER_PINS+1];
   assign onoff_s  = pins_s[USER_PINS+2];

   // Grace delay before the analog section goes down
   delay_timer u_grace (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (grace_if.timer)
   );

   // Settle delay before a routed wake reaches ext_irq0
   delay_timer u_settle (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tif     (settle_if.timer)
   );

   assign grace_if.start   = grace_go;
   assign grace_if.length  = GRACE_LOAD;

   assign settle_if.start  = settle_go;
   assign settle_if.length = SETTLE_LOAD;

   // A source requests only when its flag and enable are both set
   assign periph_req[0] = core_ff.ext_ctrl[RTC_FL_BIT]
                        & core_ff.ext_ctrl[RTC_EN_BIT];

   assign periph_req[1] = core_ff.ext_ctrl[USB_FL_BIT]
                        & core_ff.ext_ctrl[USB_EN_BIT];

   assign periph_req[2] = core_ff.ext_ctrl[KP_FL_BIT]
                        & core_ff.ext_ctrl[KP_EN_BIT];

   assign irq5_src = |periph_req;
   assign irq4_src = smartcard_irq;
   assign irq0_src = |user_s;
   assign wake_any = irq5_src | irq4_src | irq0_src;
   assign route    = core_ff.ext_ctrl[ROUTE_BIT];

   // Address phase decode; unmapped addresses select nothing
   assign addr_valid = hsel && htrans[1] && hready;
   always_comb begin
      addr_sel = SEL_NONE;
      if (haddr == EXT_CTRL_ADDR) begin
         addr_sel = SEL_EXT;
      end else if (haddr == MISC_CTRL_ADDR) begin
         addr_sel = SEL_MISC;
      end else if (haddr == IRQ_STAT_ADDR) begin
         addr_sel = SEL_STAT;
      end else if (haddr == IRQ_MASK_ADDR) begin
         addr_sel = SEL_MASK;
      end else begin
         addr_sel = SEL_NONE;
      end
   end

   // Writes first, then events, then read capture, so a read
   // sees a write done just before it
   always_comb begin
      nxt_core  = core_ff;
      grace_go  = 1'b0;
      settle_go = 1'b0;

      // Data phase of a write
      case (core_ff.wr_sel)
         SEL_EXT: begin
            // Route and enables plain; flags only cleared by a zero
            nxt_core.ext_ctrl = (hwdata[7:0] & EXT_RW_MASK)
                              | (hwdata[7:0] & core_ff.ext_ctrl
                                 & EXT_FL_MASK);
            if (!hwdata[ROUTE_BIT]) begin
               nxt_core.wake_pending = 1'b0;
            end
         end

         SEL_MISC: begin
            nxt_core.misc = hwdata[7:0] & MISC_WR_MASK;
         end

         SEL_STAT: begin
            nxt_core.irq_status = core_ff.irq_status & ~hwdata[1:0];
         end

         SEL_MASK: begin
            nxt_core.irq_mask = hwdata[1:0];
         end

         default: begin
            nxt_core.wr_sel = SEL_NONE;
         end
      endcase

      // Peripheral events set flags; a set beats a clear
      if (rtc_event) begin
         nxt_core.ext_ctrl[RTC_FL_BIT] = 1'b1;
      end

      if (usb_event) begin
         nxt_core.ext_ctrl[USB_FL_BIT] = 1'b1;
      end

      if (keypad_event) begin
         nxt_core.ext_ctrl[KP_FL_BIT] = 1'b1;
      end

      // Power-down sequencer
      case (core_ff.st)
         ST_RUN: begin
            if (core_ff.misc[PD_BIT]) begin
               // Firmware stops its core during this grace time
               grace_go    = 1'b1;
               nxt_core.st = ST_GRACE;
            end else if (route && wake_any && !core_ff.wake_pending) begin
               // Routed source while running still sees the delay
               settle_go   = 1'b1;
               nxt_core.st = ST_SETTLE;
            end
         end

         ST_GRACE: begin
            if (grace_if.done) begin
               nxt_core.st = ST_DOWN;
               nxt_core.irq_status[STAT_STANDBY_BIT] = 1'b1;
            end
         end

         ST_DOWN: begin
            // Only the ORed wake sources wake it
            if (wake_any) begin
               nxt_core.st = ST_RESTART;
            end
         end

         ST_RESTART: begin
            // Count only once the clocks run again
            if (clk_ok_s) begin
               settle_go   = 1'b1;
               nxt_core.st = ST_SETTLE;
            end
         end

         ST_SETTLE: begin
            if (settle_if.done) begin
               nxt_core.st            = ST_RUN;
               nxt_core.misc[PD_BIT]  = 1'b0;
               nxt_core.wake_pending  = route;
               nxt_core.irq_status[STAT_WAKE_BIT] = 1'b1;
            end
         end

         default: begin
            nxt_core.st = ST_RUN;
         end
      endcase

      // Address phase: capture read data, note a write
      nxt_core.wr_sel = SEL_NONE;
      if (addr_valid) begin
         if (hwrite) begin
            nxt_core.wr_sel = addr_sel;
            nxt_core.rdata  = 32'h0000_0000;
         end else begin
            nxt_core.rdata = 32'h0000_0000;
            case (addr_sel)

               SEL_EXT: begin
                  nxt_core.rdata[7:0] = nxt_core.ext_ctrl;
                  // A read drops the route
                  nxt_core.ext_ctrl[ROUTE_BIT] = 1'b0;
                  nxt_core.wake_pending        = 1'b0;
               end

               SEL_MISC: begin
                  nxt_core.rdata[7:0] = nxt_core.misc;
               end

               SEL_STAT: begin
                  nxt_core.rdata[1:0] = nxt_core.irq_status;
               end

               SEL_MASK: begin
                  nxt_core.rdata[1:0] = nxt_core.irq_mask;
               end

               default: begin
                  nxt_core.rdata = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_ff.st           <= ST_RUN;
         core_ff.ext_ctrl     <= EXT_CTRL_RST;
         core_ff.misc         <= MISC_CTRL_RST;
         core_ff.irq_status   <= IRQ_RST;
         core_ff.irq_mask     <= IRQ_RST;
         core_ff.wake_pending <= 1'b0;
         core_ff.wr_sel       <= SEL_NONE;
         core_ff.rdata        <= 32'h0000_0000;
      end else begin
         core_ff <= nxt_core;
      end
   end

   // Bus answers: no wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = core_ff.rdata;

   // Routed sources leave their own lines and reach ext_irq0 late
   assign ext_irq5 = !route && irq5_src;
   assign ext_irq4 = !route && irq4_src;
   assign ext_irq0 = route ? core_ff.wake_pending
                           : irq0_src;

   // Block interrupt: level while an unmasked event is pending
   assign irq = |(core_ff.irq_status & core_ff.irq_mask);

   // Power controls follow the sequencer state
   assign analog_clock_off = (core_ff.st == ST_DOWN);

   // With no bus power and switch off a powered-down device goes fully off
   assign converter_off    = (core_ff.st == ST_DOWN)
                           && !vbus_s && !onoff_s;
   assign mpu_halt         = core_ff.misc[PD_BIT]
                           && (core_ff.st == ST_DOWN
                               || core_ff.st == ST_RESTART
                               || core_ff.st == ST_SETTLE);

   // RTC survives power-down only on its own 32kHz oscillator
   assign rtc_run          = (core_ff.st != ST_DOWN)
                           || rtc_on_32k;

   assign power_save_override = core_ff.misc[PD_BIT];
   assign serial_loopback     = core_ff.misc[LOOP_BIT];
   assign serial_pin_select   = core_ff.misc[PINSEL_BIT];

   // Only word transfers; hsize is not decoded
   logic unused_size;
   assign unused_size = ^hsize;
endmodule // power_down_wake_control

/* rtl/pwr_wake_pkg.sv */
/*
  Constants, register map and types for the power-down and wake control.
  Assumes an AHB-Lite slave with 32-bit data and word access only.
*/
// Summary of operation
// - Route bit steers wake sources onto ext_irq0
// - Routed ext_irq0 assertion delayed 512 clocks
// - Reading wake control register clears route bit
// - RTC enable bit 5, flag bit 4
// - USB enable bit 3, flag bit 2
// - Keypad enable bit 1, flag bit 0
// - Analog and clocks off 32 clocks after request
// - RTC keeps running on 32kHz oscillator
// - MPU halted while powered down
// - Power-down request overrides other power bits
// - Misc bit 1 selects UART loopback
// - Misc bit 0 selects serial port pins
// - Wake on ORed ext_irq0, 4, 5 sources
// - Restart clocks, then count settle delay
// - Powered down, no bus power, switch off: full off
package pwr_wake_pkg;
   // Register indices; byte address is four times the index
   localparam logic [31:0] EXT_CTRL_INDEX  = 32'h0000_FF94;
   localparam logic [31:0] MISC_CTRL_INDEX = 32'h0000_FFF1;
   localparam logic [31:0] EXT_CTRL_ADDR   = EXT_CTRL_INDEX << 2;
   localparam logic [31:0] MISC_CTRL_ADDR  = MISC_CTRL_INDEX << 2;
   localparam logic [31:0] IRQ_STAT_ADDR   = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_ADDR   = 32'h0000_0004;
   // Reset values
   localparam logic [7:0]  EXT_CTRL_RST    = 8'h00;
   localparam logic [7:0]  MISC_CTRL_RST   = 8'h00;
   localparam logic [1:0]  IRQ_RST         = 2'h0;
   // Wake control field positions
   localparam int ROUTE_BIT   = 7;
   localparam int RTC_EN_BIT  = 5;
   localparam int RTC_FL_BIT  = 4;
   localparam int USB_EN_BIT  = 3;
   localparam int USB_FL_BIT  = 2;
   localparam int KP_EN_BIT   = 1;
   localparam int KP_FL_BIT   = 0;
   // Misc control field positions, writable masks and wake flag mask
   localparam int PD_BIT      = 7;
   localparam int LOOP_BIT    = 1;
   localparam int PINSEL_BIT  = 0;
   localparam logic [7:0] MISC_WR_MASK = 8'h83;
   localparam logic [7:0] EXT_RW_MASK  = 8'hAA;
   localparam logic [7:0] EXT_FL_MASK  = 8'h15;
   // Interrupt status positions
   localparam int STAT_WAKE_BIT    = 0;
   localparam int STAT_STANDBY_BIT = 1;
   // Timing in MPU clock cycles
   localparam int CNT_W = 10;
   localparam int GRACE_CYCLES  = 32;
   localparam int SETTLE_CYCLES = 512;
   localparam logic [CNT_W-1:0] GRACE_LOAD  = CNT_W'(GRACE_CYCLES - 1);
   localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);
   // Pin synchroniser width: user pins, clock ok, bus power, switch
   localparam int USER_PINS = 8;
   localparam int SYNC_W    = USER_PINS + 3;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_RUN, ST_GRACE, ST_DOWN, ST_RESTART, ST_SETTLE
   } pd_state_t;
   // Register selected by a bus access
   typedef enum logic [2:0] {
      SEL_NONE, SEL_EXT, SEL_MISC, SEL_STAT, SEL_MASK
   } reg_sel_t;
endpackage

/* rtl/timer_if.sv */
/*
  Start and done handshake between the sequencer and a delay timer.
  Assumes both ends run on hclk.
*/
`timescale 1ns/10ps
interface timer_if;
   logic                          start;  // One-cycle start pulse
   logic [pwr_wake_pkg::CNT_W-1:0] length; // Cycles to count, less one
   logic                          done;   // One-cycle expiry pulse
   logic                          busy;   // Counting
   modport ctrl  (output start, output length, input done, input busy);
   modport timer (input start, input length, output done, output busy);
endinterface

/* testbench/periph_model.sv */
/* Interrupt sources and user pins at the block's far side.
   Tasks are entered just after a rising hclk edge. */
`timescale 1ns/10ps
module periph_model (
   input  wire logic                          hclk,
   output logic                               rtc_event,
   output logic                               usb_event,
   output logic                               keypad_event,
   output logic                               smartcard_irq,
   output logic [pwr_wake_pkg::USER_PINS-1:0] user_pins
);
   import pwr_wake_pkg::*;
   // All sources quiet at time zero
   initial {rtc_event, usb_event, keypad_event, smartcard_irq, user_pins} = '0;
   // One-cycle event: 0 keypad, 1 usb, 2 rtc
   task automatic pulse(input int k);
      {rtc_event, usb_event, keypad_event} <= 3'(1 << k);
      @(posedge hclk);
      {rtc_event, usb_event, keypad_event} <= 3'h0;
   endtask
   // Levels hold until changed
   task automatic levels(input logic c, input logic [USER_PINS-1:0] p);
      smartcard_irq <= c;
      user_pins <= p;
   endtask
endmodule // periph_model

/* testbench/power_down_wake_control_properties.sv */
/* Port checker of the power-down and wake control.
   Assumes one clock hclk, reset hresetn active low. */
`timescale 1ns/10ps
module pdwc_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       analog_clock_off,
   input wire logic       converter_off,
   input wire logic       mpu_halt,
   input wire logic       rtc_run,
   input wire logic       rtc_on_32k,
   input wire logic       power_save_override,
   input wire logic       serial_loopback,
   input wire logic       serial_pin_select
);
   logic [9:0] halt_run_ff;  // Consecutive halted cycles with analog_clock_off low
   logic [9:0] nxt_halt_run; // Next count
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Saturates, so a long halt cannot wrap small
   always_comb begin
      nxt_halt_run = 10'h000;
      if (mpu_halt && !analog_clock_off)
         nxt_halt_run = halt_run_ff + {9'h000, halt_run_ff != 10'h3FF};
   end
   // Count register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) halt_run_ff <= 10'h000;
      else halt_run_ff <= nxt_halt_run;
   end
   property p_okay;
      hreadyout && !hresp;
   endproperty
   property p_grace;
      $rose(power_save_override) |->
         !analog_clock_off [*8] ##[20:26] analog_clock_off;
   endproperty
   property p_halt;
      analog_clock_off |-> mpu_halt;
   endproperty
   property p_rtc;
      rtc_run == (!analog_clock_off || rtc_on_32k);
   endproperty
   property p_conv;
      converter_off |-> analog_clock_off;
   endproperty
   property p_pso;
      analog_clock_off |-> power_save_override;
   endproperty
   property p_wrctl;
      ($changed({serial_loopback, serial_pin_select})
         || $rose(power_save_override))
         |-> $past(hsel && hwrite && htrans[1], 2);
   endproperty
   property p_settle;
      $fell(mpu_halt) |-> halt_run_ff >= 10'h200;
   endproperty
   property p_wakehold;
      $fell(analog_clock_off) |-> mpu_halt [*8];
   endproperty
   a_okay: assert property (p_okay)
      else $error("bad slave answer");
   a_grace: assert property (p_grace)
      else $error("grace time wrong");
   a_halt: assert property (p_halt)
      else $error("core runs in power down");
   a_rtc: assert property (p_rtc)
      else $error("rtc run wrong");
   a_conv: assert property (p_conv)
      else $error("converter off while up");
   a_pso: assert property (p_pso)
      else $error("down without override");
   a_wrctl: assert property (p_wrctl)
      else $error("control changed unwritten");
   a_settle: assert property (p_settle)
      else $error("core freed before settle");
   a_wakehold: assert property (p_wakehold)
      else $error("core freed at once");
   c_down: cover property ($rose(analog_clock_off));
   c_off: cover property ($rose(converter_off));
   c_back: cover property ($fell(mpu_halt));
endmodule // pdwc_props

bind power_down_wake_control pdwc_props pdwc_props_i (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hreadyout, .hresp,
   .analog_clock_off, .converter_off, .mpu_halt, .rtc_run, .rtc_on_32k,
   .power_save_override, .serial_loopback, .serial_pin_select
);

/* testbench/power_down_wake_control_tb_top.sv */
/* Self-checking bench for the power-down and wake control.
   Assumes the block is the only AHB-Lite slave. */
`timescale 1ns/10ps
module power_down_wake_control_tb_top;
   import pwr_wake_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        rtc_event, usb_event, keypad_event, smartcard_irq;
   logic        clocks_stable, vbus_present, onoff_on, rtc_on_32k;
   logic        ext_irq0, ext_irq4, ext_irq5, irq, analog_clock_off;
   logic        converter_off, mpu_halt, rtc_run, power_save_override;
   logic        serial_loopback, serial_pin_select;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  user_pins;
   int          failures, check_count, cycles;

   power_down_wake_control power_down_wake_control_i (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rtc_event,
      .usb_event, .keypad_event, .smartcard_irq, .user_pins,
      .clocks_stable, .vbus_present, .onoff_on, .rtc_on_32k, .ext_irq0,
      .ext_irq4, .ext_irq5, .irq, .analog_clock_off, .converter_off,
      .mpu_halt, .rtc_run, .power_save_override, .serial_loopback,
      .serial_pin_select
   );
   periph_model periph_model_i (
      .hclk, .rtc_event, .usb_event, .keypad_event, .smartcard_irq,
      .user_pins
   );

   // 250 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // Counts, verdict, stop
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard; a run takes under 2000 cycles
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         complete_run();
      end
   end

   task automatic chk(input string w, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask

   // One transfer; read data taken at its last edge
   task automatic wr(input logic [31:0] a, d, input logic w = 1'b1);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [31:0] a, e, input string w);
      wr(a, 32'h0000_0000, 1'b0);
      chk(w, e, hrdata);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Edges until ext_irq0 (0) or analog_clock_off (1) is lvl
   task automatic wait_for(input int s, input logic lvl, output int n);
      n = 0;
      while ((s == 0 ? ext_irq0 : analog_clock_off) !== lvl && n < 2000)
      begin
         @(posedge hclk);
         n++;
      end
   endtask

   initial begin
      int          n;
      logic [31:0] fl;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {failures, check_count, cycles} = '0;
      hsize = 3'h2;
      {clocks_stable, rtc_on_32k, vbus_present, onoff_on} = 4'hC;
      tick(12);
      hresetn <= 1'b1;
      tick(1);
      // Reset values, then an unmapped place
      rd(EXT_CTRL_ADDR, 32'h0000_0000, "ext ctrl");
      rd(MISC_CTRL_ADDR, 32'h0000_0000, "misc");
      rd(IRQ_STAT_ADDR, 32'h0000_0000, "status");
      rd(IRQ_MASK_ADDR, 32'h0000_0000, "mask");
      rd(32'h0000_0100, 32'h0000_0000, "unmapped");
      // Reserved bits dropped; read just after write
      wr(MISC_CTRL_ADDR, 32'h0000_007F);
      rd(MISC_CTRL_ADDR, 32'h0000_0003, "misc");
      chk("loopback", 32'h1, 32'(serial_loopback));
      chk("pin select", 32'h1, 32'(serial_pin_select));
      wr(MISC_CTRL_ADDR, 32'h0000_0001);
      tick(1);
      chk("loopback off", 32'h0, 32'(serial_loopback));
      // Each source: flag, flag with enable, cleared
      for (int k = 0; k < 3; k++) begin
         fl = 32'h1 << (2 * k);
         periph_model_i.pulse(k);
         tick(2);
         rd(EXT_CTRL_ADDR, fl, "flag");
         chk("irq5 off", 32'h0, 32'(ext_irq5));
         wr(EXT_CTRL_ADDR, fl * 3);
         tick(1);
         chk("irq5 on", 32'h1, 32'(ext_irq5));
         wr(EXT_CTRL_ADDR, 32'h0000_0000);
         rd(EXT_CTRL_ADDR, 32'h0000_0000, "cleared");
      end
      // Routed card interrupt while running; read clears route
      wr(EXT_CTRL_ADDR, 32'h0000_0080);
      periph_model_i.levels(1'b1, 8'h00);
      wait_for(0, 1'b1, n);
      chk("route delay", 32'h1, 32'(n >= 510 && n <= 516));
      chk("irq4 routed", 32'h0, 32'(ext_irq4));
      rd(EXT_CTRL_ADDR, 32'h0000_0080, "route");
      tick(1);
      chk("irq0 dropped", 32'h0, 32'(ext_irq0));
      chk("irq4 back", 32'h1, 32'(ext_irq4));
      rd(EXT_CTRL_ADDR, 32'h0000_0000, "route gone");
      periph_model_i.levels(1'b0, 8'h00);
      // Power down with route set first, woken by a user pin
      wr(IRQ_MASK_ADDR, 32'h0000_0003);
      rd(IRQ_MASK_ADDR, 32'h0000_0003, "mask");
      wr(EXT_CTRL_ADDR, 32'h0000_0080);
      wr(MISC_CTRL_ADDR, 32'h0000_0080);
      wait_for(1, 1'b1, n);
      chk("grace", 32'h1, 32'(n >= 32 && n <= 33));
      rtc_on_32k <= 1'b0;
      tick(2);
      chk("halt", 32'h1, 32'(mpu_halt));
      chk("rtc stopped", 32'h0, 32'(rtc_run));
      chk("converter", 32'h1, 32'(converter_off));
      chk("override", 32'h1, 32'(power_save_override));
      chk("irq standby", 32'h1, 32'(irq));
      rtc_on_32k <= 1'b1;
      periph_model_i.levels(1'b0, 8'h10);
      wait_for(1, 1'b0, n);
      wait_for(0, 1'b1, n);
      chk("settle", 32'h1, 32'(n >= 512 && n <= 516));
      rd(MISC_CTRL_ADDR, 32'h0000_0000, "pd cleared");
      rd(IRQ_STAT_ADDR, 32'h0000_0003, "status");
      wr(IRQ_MASK_ADDR, 32'h0000_0000);
      tick(1);
      chk("irq masked", 32'h0, 32'(irq));
      wr(IRQ_STAT_ADDR, 32'h0000_0003);
      rd(IRQ_STAT_ADDR, 32'h0000_0000, "status clear");
      periph_model_i.levels(1'b0, 8'h00);
      complete_run();
   end
endmodule // power_down_wake_control_tb_top
